/* File: include/cioc_pkg.sv */
// package: register map, configuration layout and carriers of the io cell
package cioc_pkg;
  localparam int unsigned AXI_AW      = 8;
  localparam logic [7:0]  CFG_OFF     = 8'h00;
  localparam logic [7:0]  CTRL_OFF    = 8'h04;
  localparam logic [7:0]  STAT_OFF    = 8'h08;
  localparam int unsigned CTRL_DONE   = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic        DONE_RST    = 1'b0;
  localparam int unsigned CHAIN_LEN   = 3;
  localparam int unsigned CHAIN_PAD   = 0;
  localparam int unsigned CHAIN_OUT   = 1;
  localparam int unsigned CHAIN_OE    = 2;

  typedef enum logic [1:0] {
    CIOC_SYNC_SET,
    CIOC_SYNC_RST,
    CIOC_ASYNC_PRE,
    CIOC_ASYNC_CLR
  } cioc_srm_t;

  // configuration word, msb first
  typedef struct packed {
    logic [8:0] unused;
    logic       keeper;
    logic       pull_dn;
    logic       pull_up;
    cioc_srm_t  srm_oe;
    cioc_srm_t  srm_out;
    cioc_srm_t  srm_in;
    logic       latch_oe;
    logic       latch_out;
    logic       latch_in;
    logic       oe_inv;
    logic       sr_inv;
    logic       ce_oe_inv;
    logic       ce_out_inv;
    logic       ce_in_inv;
    logic       clk_inv;
    logic       out_inv;
    logic       oe_reg;
    logic       out_reg;
    logic       in_dly;
    logic       in_reg;
  } cioc_cfg_t;

  localparam cioc_cfg_t CFG_RST = '0;

  // pin inputs that cross into clk
  typedef struct packed {
    logic scan_extest;
    logic scan_update;
    logic scan_capture;
    logic scan_shift;
    logic scan_tdi;
    logic scan_tck;
    logic mode_pullup;
    logic pad;
  } cioc_pins_t;

  localparam cioc_pins_t PINS_RST = '0;

  typedef struct packed {
    logic [25:0] unused;
    logic        done;
    logic        keep;
    logic        oe_q;
    logic        out_q;
    logic        in_q;
    logic        pad;
  } cioc_stat_t;
endpackage

/* File: design/cioc_store.sv */
// storage element: flip-flop or latch with shared set/reset modes
`timescale 1ns/1ps
module cioc_store (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                d,
  input  wire logic                ce,
  input  wire logic                edge_p,
  input  wire logic                gate,
  input  wire logic                sr,
  input  wire logic                latch,
  input  wire cioc_pkg::cioc_srm_t mode,
  output logic                     q_q
);
  logic q_d;
  logic is_async;
  logic is_set;
  logic upd;

  always_comb begin
    is_async = (mode == cioc_pkg::CIOC_ASYNC_PRE) || (mode == cioc_pkg::CIOC_ASYNC_CLR);
    is_set   = (mode == cioc_pkg::CIOC_SYNC_SET) || (mode == cioc_pkg::CIOC_ASYNC_PRE);
    upd      = latch ? gate : edge_p;
    q_d      = q_q;
    if (sr && is_async) begin
      q_d = is_set;
    end else if (upd && sr) begin
      q_d = is_set;
    end else if (upd && ce) begin
      q_d = d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_async_force: assert property (sr && is_async |=> q_q == $past(is_set))
    else $error("async set/reset did not force the element");
  a_sync_wait: assert property (sr && !is_async && !upd |=> $stable(q_q))
    else $error("sync set/reset acted without a clock edge");
  a_ce_hold: assert property (!sr && !ce |=> $stable(q_q))
    else $error("element changed while its enable was low");
  a_edge_load: assert property (!sr && ce && !latch && edge_p |=> q_q == $past(d))
    else $error("flip-flop did not load on its edge");
endmodule

/* File: design/cioc_scan.sv */
// boundary-scan chain of the cell: capture, shift and update stages
`timescale 1ns/1ps
module cioc_scan (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           tck,
  input  wire logic                           tdi,
  input  wire logic                           shift,
  input  wire logic                           capture,
  input  wire logic                           update,
  input  wire logic [cioc_pkg::CHAIN_LEN-1:0] cap,
  output logic                                tdo_q,
  output logic      [cioc_pkg::CHAIN_LEN-1:0] upd_q
);
  logic                           tck_q;
  logic                           rise;
  logic [cioc_pkg::CHAIN_LEN-1:0] chain_q;
  logic [cioc_pkg::CHAIN_LEN-1:0] chain_d;
  logic [cioc_pkg::CHAIN_LEN-1:0] upd_d;

  always_comb begin
    rise    = tck && !tck_q;
    chain_d = chain_q;
    upd_d   = upd_q;
    if (rise && capture) begin
      chain_d = cap;
    end else if (rise && shift) begin
      chain_d = {tdi, chain_q[cioc_pkg::CHAIN_LEN-1:1]};
    end
    if (rise && update) begin
      upd_d = chain_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tck_q   <= 1'b0;
      chain_q <= '0;
      upd_q   <= '0;
      tdo_q   <= 1'b0;
    end else begin
      tck_q   <= tck;
      chain_q <= chain_d;
      upd_q   <= upd_d;
      tdo_q   <= chain_d[0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_shift_move: assert property (rise && shift && !capture |=>
    chain_q[cioc_pkg::CHAIN_LEN-1] == $past(tdi) && tdo_q == $past(chain_q[1]))
    else $error("scan shift lost a bit");
endmodule

/* File: design/cioc_top.sv */
// configurable io cell with axi4-lite configuration port
//
// Operation
// - the cell holds input, output and output-enable elements, each a flip-flop or a latch.
// - all three share one cell clock and each has its own clock enable gating its updates.
// - one shared set/reset acts per element as sync set, sync reset, async preset or async clear.
// - output data and each control input (clock, enables, set/reset, enable) can be inverted separately.
// - before configuration is done the pad floats, pull-down and keeper are off, only pull-up may be on.
// - the pull-up before configuration is one global choice from the mode pins, else the pad floats.
// - the pad level reaches the fabric directly or through the input element, by configuration.
// - an optional delay stands in front of the input element data to make pad hold time zero.
// - after configuration each pad offers a selectable pull-up or pull-down.
// - pad output data comes directly from the fabric or through the output element.
// - the driver enable comes directly from the fabric or through its own element.
// - with the keeper on, the cell weakly drives the pad to its sensed level.
// - every cell takes part in boundary-scan test through a capture, shift and update chain.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module cioc_top (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [cioc_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                        wvalid,
  output logic                             wready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  output logic                             bvalid,
  input  wire logic                        bready,
  output logic      [1:0]                  bresp,
  input  wire logic                        arvalid,
  output logic                             arready,
  input  wire logic [cioc_pkg::AXI_AW-1:0] araddr,
  output logic                             rvalid,
  input  wire logic                        rready,
  output logic      [31:0]                 rdata,
  output logic      [1:0]                  rresp,
  input  wire logic                        pad_i,
  input  wire logic                        mode_pullup,
  input  wire logic                        scan_tck,
  input  wire logic                        scan_tdi,
  input  wire logic                        scan_shift,
  input  wire logic                        scan_capture,
  input  wire logic                        scan_update,
  input  wire logic                        scan_extest,
  input  wire logic                        fab_clk,
  input  wire logic                        fab_o,
  input  wire logic                        fab_oe,
  input  wire logic                        fab_ce_in,
  input  wire logic                        fab_ce_out,
  input  wire logic                        fab_ce_oe,
  input  wire logic                        fab_sr,
  output logic                             fab_in_q,
  output logic                             pad_o_q,
  output logic                             pad_oe_q,
  output logic                             pad_pu_q,
  output logic                             pad_pd_q,
  output logic                             pad_keep_oe_q,
  output logic                             pad_keep_o_q,
  output logic                             scan_tdo_q
);
  // pin synchroniser; only s2 is read
  cioc_pkg::cioc_pins_t pins_raw;
  cioc_pkg::cioc_pins_t pins_s1_q;
  cioc_pkg::cioc_pins_t pins_s2_q;
  assign pins_raw = '{scan_extest: scan_extest, scan_update: scan_update, scan_capture: scan_capture,
                      scan_shift: scan_shift, scan_tdi: scan_tdi, scan_tck: scan_tck,
                      mode_pullup: mode_pullup, pad: pad_i};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pins_s1_q <= cioc_pkg::PINS_RST;
      pins_s2_q <= cioc_pkg::PINS_RST;
    end else begin
      pins_s1_q <= pins_raw;
      pins_s2_q <= pins_s1_q;
    end
  end
  // register file and axi4-lite slave
  cioc_pkg::cioc_cfg_t       cfg_q;
  cioc_pkg::cioc_cfg_t       cfg_d;
  logic                      done_q;
  logic                      done_d;
  logic                      aw_got_q;
  logic                      aw_got_d;
  logic                      w_got_q;
  logic                      w_got_d;
  logic [cioc_pkg::AXI_AW-1:0] waddr_q;
  logic [cioc_pkg::AXI_AW-1:0] waddr_d;
  logic [31:0]               wdat_q;
  logic [31:0]               wdat_d;
  logic [3:0]                wstb_q;
  logic [3:0]                wstb_d;
  logic                      awready_d;
  logic                      wready_d;
  logic                      bvalid_d;
  logic [1:0]                bresp_d;
  logic                      arready_d;
  logic                      rvalid_d;
  logic [31:0]               rdata_d;
  logic [1:0]                rresp_d;
  logic                      do_wr;
  logic [31:0]               cfg_w;
  cioc_pkg::cioc_stat_t      stat;
  logic                      q_in;
  logic                      q_out;
  logic                      q_oe;
  always_comb begin
    stat     = '{unused: '0, done: done_q, keep: pad_keep_oe_q, oe_q: q_oe,
                 out_q: q_out, in_q: q_in, pad: pins_s2_q.pad};
    aw_got_d = aw_got_q || (awvalid && awready);
    w_got_d  = w_got_q || (wvalid && wready);
    waddr_d  = (awvalid && awready) ? awaddr : waddr_q;
    wdat_d   = (wvalid && wready) ? wdata : wdat_q;
    wstb_d   = (wvalid && wready) ? wstrb : wstb_q;
    do_wr    = aw_got_q && w_got_q && !bvalid;
    cfg_w    = cfg_q;
    cfg_d    = cfg_q;
    done_d   = done_q;
    bvalid_d = bvalid && !bready;
    bresp_d  = bresp;
    // byte lanes merged per strobe
    for (int b = 0; b < 4; b++) begin
      if (wstb_q[b]) begin
        cfg_w[8*b +: 8] = wdat_q[8*b +: 8];
      end
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = cioc_pkg::RESP_OKAY;
      if (waddr_q == cioc_pkg::CFG_OFF) begin
        cfg_d = cioc_pkg::cioc_cfg_t'(cfg_w);
      end else if (waddr_q == cioc_pkg::CTRL_OFF) begin
        if (wstb_q[0]) begin
          done_d = wdat_q[cioc_pkg::CTRL_DONE];
        end
      end else if (waddr_q != cioc_pkg::STAT_OFF) begin
        bresp_d = cioc_pkg::RESP_SLVERR;
      end
    end
    awready_d = !aw_got_d && !bvalid_d;
    wready_d  = !w_got_d && !bvalid_d;
    rvalid_d  = rvalid && !rready;
    rdata_d   = rdata;
    rresp_d   = rresp;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = cioc_pkg::RESP_OKAY;
      unique case (araddr)
        cioc_pkg::CFG_OFF:  rdata_d = cfg_q;
        cioc_pkg::CTRL_OFF: rdata_d = {31'h0, done_q};
        cioc_pkg::STAT_OFF: rdata_d = stat;
        default: begin
          rdata_d = 32'h0;
          rresp_d = cioc_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q    <= cioc_pkg::CFG_RST;
      done_q   <= cioc_pkg::DONE_RST;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= '0;
      wdat_q   <= 32'h0;
      wstb_q   <= 4'h0;
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= cioc_pkg::RESP_OKAY;
      arready  <= 1'b1;
      rvalid   <= 1'b0;
      rdata    <= 32'h0;
      rresp    <= cioc_pkg::RESP_OKAY;
    end else begin
      cfg_q    <= cfg_d;
      done_q   <= done_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      waddr_q  <= waddr_d;
      wdat_q   <= wdat_d;
      wstb_q   <= wstb_d;
      awready  <= awready_d;
      wready   <= wready_d;
      bvalid   <= bvalid_d;
      bresp    <= bresp_d;
      arready  <= arready_d;
      rvalid   <= rvalid_d;
      rdata    <= rdata_d;
      rresp    <= rresp_d;
    end
  end
  // cell clock and controls; the cell clock is sampled only for edge detection, so its edge shows in the clk cycle it rises
  logic cclk;
  logic cclk_q;
  logic cedge;
  logic sr_act;
  logic pad_dly_q;
  logic d_in;
  logic d_oe;
  logic out_core;
  logic oe_core;
  logic extest;
  logic [cioc_pkg::CHAIN_LEN-1:0] scan_upd;
  logic [cioc_pkg::CHAIN_LEN-1:0] scan_cap;
  logic fab_in_d;
  logic pad_o_d;
  logic pad_oe_d;
  logic pad_pu_d;
  logic pad_pd_d;
  logic keep_oe_d;
  always_comb begin
    cclk     = fab_clk ^ cfg_q.clk_inv;
    cedge    = cclk && !cclk_q;
    sr_act   = fab_sr ^ cfg_q.sr_inv;
    d_in     = cfg_q.in_dly ? pad_dly_q : pins_s2_q.pad;
    d_oe     = fab_oe ^ cfg_q.oe_inv;
    extest   = pins_s2_q.scan_extest;
    out_core = (cfg_q.out_reg ? q_out : fab_o) ^ cfg_q.out_inv;
    oe_core  = cfg_q.oe_reg ? q_oe : d_oe;
    fab_in_d = cfg_q.in_reg ? q_in : pins_s2_q.pad;
    scan_cap = {oe_core, out_core, pins_s2_q.pad};
    // unconfigured pad floats; only the global pull-up may act
    pad_o_d   = extest ? scan_upd[cioc_pkg::CHAIN_OUT] : out_core;
    pad_oe_d  = 1'b0;
    pad_pu_d  = pins_s2_q.mode_pullup;
    pad_pd_d  = 1'b0;
    keep_oe_d = 1'b0;
    if (done_q) begin
      pad_oe_d  = extest ? scan_upd[cioc_pkg::CHAIN_OE] : oe_core;
      pad_pu_d  = cfg_q.pull_up;
      pad_pd_d  = cfg_q.pull_dn && !cfg_q.pull_up;
      keep_oe_d = cfg_q.keeper;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cclk_q        <= 1'b0;
      pad_dly_q     <= 1'b0;
      fab_in_q      <= 1'b0;
      pad_o_q       <= 1'b0;
      pad_oe_q      <= 1'b0;
      pad_pu_q      <= 1'b0;
      pad_pd_q      <= 1'b0;
      pad_keep_oe_q <= 1'b0;
      pad_keep_o_q  <= 1'b0;
    end else begin
      cclk_q        <= cclk;
      pad_dly_q     <= pins_s2_q.pad;
      fab_in_q      <= fab_in_d;
      pad_o_q       <= pad_o_d;
      pad_oe_q      <= pad_oe_d;
      pad_pu_q      <= pad_pu_d;
      pad_pd_q      <= pad_pd_d;
      pad_keep_oe_q <= keep_oe_d;
      pad_keep_o_q  <= pins_s2_q.pad;
    end
  end
  // the three elements; latch gate is the cell clock level
  cioc_store u_in (
    .clk    (clk),
    .resetn (resetn),
    .d      (d_in),
    .ce     (fab_ce_in ^ cfg_q.ce_in_inv),
    .edge_p (cedge),
    .gate   (cclk),
    .sr     (sr_act),
    .latch  (cfg_q.latch_in),
    .mode   (cfg_q.srm_in),
    .q_q    (q_in)
  );
  cioc_store u_out (
    .clk    (clk),
    .resetn (resetn),
    .d      (fab_o),
    .ce     (fab_ce_out ^ cfg_q.ce_out_inv),
    .edge_p (cedge),
    .gate   (cclk),
    .sr     (sr_act),
    .latch  (cfg_q.latch_out),
    .mode   (cfg_q.srm_out),
    .q_q    (q_out)
  );
  cioc_store u_oe (
    .clk    (clk),
    .resetn (resetn),
    .d      (d_oe),
    .ce     (fab_ce_oe ^ cfg_q.ce_oe_inv),
    .edge_p (cedge),
    .gate   (cclk),
    .sr     (sr_act),
    .latch  (cfg_q.latch_oe),
    .mode   (cfg_q.srm_oe),
    .q_q    (q_oe)
  );
  cioc_scan u_scan (
    .clk     (clk),
    .resetn  (resetn),
    .tck     (pins_s2_q.scan_tck),
    .tdi     (pins_s2_q.scan_tdi),
    .shift   (pins_s2_q.scan_shift),
    .capture (pins_s2_q.scan_capture),
    .update  (pins_s2_q.scan_update),
    .cap     (scan_cap),
    .tdo_q   (scan_tdo_q),
    .upd_q   (scan_upd)
  );
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_precfg_float: assert property (!done_q |=> !pad_oe_q && !pad_pd_q && !pad_keep_oe_q)
    else $error("unconfigured pad driven, pulled down or kept");
  a_precfg_pullup: assert property (!done_q |=> pad_pu_q == $past(pins_s2_q.mode_pullup))
    else $error("pre-configuration pull-up does not follow mode pin");
  a_in_direct: assert property (!cfg_q.in_reg |=> fab_in_q == $past(pins_s2_q.pad))
    else $error("direct input path wrong");
  a_in_delay: assert property (cfg_q.in_dly |-> d_in == $past(pins_s2_q.pad))
    else $error("input delay stage missing");
  a_out_direct: assert property (!extest && !cfg_q.out_reg |=> pad_o_q == $past(fab_o ^ cfg_q.out_inv))
    else $error("direct output path or polarity wrong");
  a_oe_path: assert property (done_q && !extest && cfg_q.oe_reg |=> pad_oe_q == $past(q_oe))
    else $error("registered enable not on driver");
  a_pull_sel: assert property (done_q && cfg_q.pull_dn && !cfg_q.pull_up |=> pad_pd_q && !pad_pu_q)
    else $error("pull-down not applied after configuration");
  a_keeper_level: assert property (done_q && cfg_q.keeper |=>
    pad_keep_oe_q && pad_keep_o_q == $past(pins_s2_q.pad))
    else $error("keeper not following pad");
  a_scan_drive: assert property (done_q && extest |=>
    pad_oe_q == $past(scan_upd[cioc_pkg::CHAIN_OE]) && pad_o_q == $past(scan_upd[cioc_pkg::CHAIN_OUT]))
    else $error("extest does not drive update stage");
endmodule

/* File: sim/cioc_pad_model.sv */
// board side of the pad: external driver, pulls and keeper resolved to one level
`timescale 1ns/1ps
module cioc_pad_model (
  input  wire logic clk,
  input  wire logic pad_o_q,
  input  wire logic pad_oe_q,
  input  wire logic pad_pu_q,
  input  wire logic pad_pd_q,
  input  wire logic pad_keep_oe_q,
  input  wire logic pad_keep_o_q,
  input  wire logic ext_en,
  input  wire logic ext_val,
  output logic      pad_i
);
  logic float_q = 1'h0;

  // a floating pad must not settle to a convenient level
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  // cell driver wins; bench drives against it only under extest, where ext_en is still on
  always_comb begin
    if (pad_oe_q) begin
      pad_i = pad_o_q;
    end else if (ext_en) begin
      pad_i = ext_val;
    end else if (pad_pu_q) begin
      pad_i = 1'h1;
    end else if (pad_pd_q) begin
      pad_i = 1'h0;
    end else if (pad_keep_oe_q) begin
      pad_i = pad_keep_o_q;
    end else begin
      pad_i = float_q;
    end
  end
endmodule

/* File: sim/tb_configurable_io_cell.sv */
// self-checking bench of the io cell: axi configuration, cell paths, pulls, keeper and scan
`timescale 1ns/1ps
module tb_configurable_io_cell;
  logic        clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        pad_i, mode_pullup, scan_tck, scan_tdi, scan_shift, scan_capture, scan_update, scan_extest;
  logic        fab_clk, fab_o, fab_oe, fab_ce_in, fab_ce_out, fab_ce_oe, fab_sr, fab_in_q, pad_o_q, pad_oe_q;
  logic        pad_pu_q, pad_pd_q, pad_keep_oe_q, pad_keep_o_q, scan_tdo_q, ext_en, ext_val;
  int          fail_count = 0;
  int          n_compared = 0;

  cioc_top cioc_top_inst (.clk, .resetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .pad_i,
    .mode_pullup, .scan_tck, .scan_tdi, .scan_shift, .scan_capture, .scan_update, .scan_extest, .fab_clk,
    .fab_o, .fab_oe, .fab_ce_in, .fab_ce_out, .fab_ce_oe, .fab_sr, .fab_in_q, .pad_o_q, .pad_oe_q,
    .pad_pu_q, .pad_pd_q, .pad_keep_oe_q, .pad_keep_o_q, .scan_tdo_q);

  cioc_pad_model cioc_pad_model_inst (.clk, .pad_o_q, .pad_oe_q, .pad_pu_q, .pad_pd_q, .pad_keep_oe_q,
    .pad_keep_o_q, .ext_en, .ext_val, .pad_i);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // slow cell clock: detection, load and output stages all fit in each half
  task automatic cedge;
    fab_clk <= 1'h1;
    tick(3);
    fab_clk <= 1'h0;
    tick(3);
  endtask

  task automatic tck_pulse;
    scan_tck <= 1'h1;
    tick(4);
    scan_tck <= 1'h0;
    tick(4);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) begin
        awvalid <= 1'h0;
      end
      if (wready === 1'h1) begin
        wvalid <= 1'h0;
      end
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk_word("bresp", {30'h0, er}, {30'h0, bresp});
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) begin
        arvalid <= 1'h0;
      end
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk_word("rdata", ed, rdata);
    chk_word("rresp", {30'h0, er}, {30'h0, rresp});
    tick(1);
  endtask

  task automatic setcfg(input cioc_pkg::cioc_cfg_t c);
    wr(cioc_pkg::CFG_OFF, 32'(c), cioc_pkg::RESP_OKAY);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    cioc_pkg::cioc_cfg_t c;
    logic v;
    {resetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {scan_tck, scan_tdi, scan_shift, scan_capture, scan_update, scan_extest} = '0;
    {fab_clk, fab_o, fab_oe, fab_sr, ext_en, ext_val} = '0;
    {mode_pullup, fab_ce_in, fab_ce_out, fab_ce_oe} = '1;
    tick(6);
    resetn <= 1'h1;
    tick(1);
    // unconfigured: pull-down and keeper requests must stay dormant
    c = cioc_pkg::CFG_RST;
    c.pull_dn = 1'h1;
    c.keeper = 1'h1;
    setcfg(c);
    fab_oe <= 1'h1;
    tick(4);
    chk_bit("pad_oe_q", 1'h0, pad_oe_q);
    chk_bit("pad_pd_q", 1'h0, pad_pd_q);
    chk_bit("pad_keep_oe_q", 1'h0, pad_keep_oe_q);
    chk_bit("pad_pu_q", 1'h1, pad_pu_q);
    mode_pullup <= 1'h0;
    tick(4);
    chk_bit("pad_pu_q", 1'h0, pad_pu_q);
    rd(cioc_pkg::CFG_OFF, 32'(c), cioc_pkg::RESP_OKAY);
    rd(8'h0c, 32'h0, cioc_pkg::RESP_SLVERR);
    wr(8'h10, 32'hffffffff, cioc_pkg::RESP_SLVERR);
    fab_oe <= 1'h0;
    wr(cioc_pkg::CTRL_OFF, 32'h1, cioc_pkg::RESP_OKAY);
    rd(cioc_pkg::CTRL_OFF, 32'h1, cioc_pkg::RESP_OKAY);
    tick(3);
    chk_bit("pad_pd_q", 1'h1, pad_pd_q);
    chk_bit("pad_keep_oe_q", 1'h1, pad_keep_oe_q);
    c.pull_up = 1'h1;
    setcfg(c);
    tick(3);
    chk_bit("pad_pu_q", 1'h1, pad_pu_q);
    chk_bit("pad_pd_q", 1'h0, pad_pd_q);
    // keeper must hold the last driven level once the board lets go
    c = cioc_pkg::CFG_RST;
    c.keeper = 1'h1;
    setcfg(c);
    for (int i = 0; i < 2; i++) begin
      ext_val <= ~i[0];
      ext_en <= 1'h1;
      tick(6);
      ext_en <= 1'h0;
      tick(6);
      chk_bit("pad_keep_o_q", ~i[0], pad_keep_o_q);
    end
    c = cioc_pkg::CFG_RST;
    setcfg(c);
    fab_o <= 1'h1;
    fab_oe <= 1'h1;
    tick(3);
    chk_bit("pad_o_q", 1'h1, pad_o_q);
    chk_bit("pad_oe_q", 1'h1, pad_oe_q);
    c.out_inv = 1'h1;
    c.oe_inv = 1'h1;
    setcfg(c);
    tick(3);
    chk_bit("pad_o_q", 1'h0, pad_o_q);
    chk_bit("pad_oe_q", 1'h0, pad_oe_q);
    c = cioc_pkg::CFG_RST;
    c.out_reg = 1'h1;
    c.oe_reg = 1'h1;
    setcfg(c);
    cedge();
    fab_o <= 1'h0;
    fab_oe <= 1'h0;
    fab_ce_oe <= 1'h0;
    tick(4);
    chk_bit("pad_o_q", 1'h1, pad_o_q);
    cedge();
    chk_bit("pad_o_q", 1'h0, pad_o_q);
    chk_bit("pad_oe_q", 1'h1, pad_oe_q);
    fab_ce_oe <= 1'h1;
    cedge();
    chk_bit("pad_oe_q", 1'h0, pad_oe_q);
    // every set/reset mode, with clock enable off so only set/reset can move the element
    for (int m = 0; m < 4; m++) begin
      c = cioc_pkg::CFG_RST;
      c.out_reg = 1'h1;
      c.srm_out = cioc_pkg::cioc_srm_t'(m);
      setcfg(c);
      v = (m == 0 || m == 2);
      fab_o <= ~v;
      fab_ce_out <= 1'h1;
      cedge();
      fab_sr <= 1'h1;
      fab_ce_out <= 1'h0;
      tick(4);
      chk_bit("pad_o_q sr early", (m >= 2) ? v : ~v, pad_o_q);
      cedge();
      chk_bit("pad_o_q sr edge", v, pad_o_q);
      fab_sr <= 1'h0;
      tick(1);
    end
    c.srm_out = cioc_pkg::CIOC_SYNC_SET;
    c.latch_out = 1'h1;
    setcfg(c);
    fab_ce_out <= 1'h1;
    fab_clk <= 1'h1;
    fab_o <= 1'h1;
    tick(4);
    chk_bit("pad_o_q latch", 1'h1, pad_o_q);
    fab_o <= 1'h0;
    tick(4);
    chk_bit("pad_o_q latch", 1'h0, pad_o_q);
    fab_clk <= 1'h0;
    tick(2);
    fab_o <= 1'h1;
    tick(4);
    chk_bit("pad_o_q latch", 1'h0, pad_o_q);
    c = cioc_pkg::CFG_RST;
    setcfg(c);
    ext_en <= 1'h1;
    ext_val <= 1'h1;
    tick(4);
    chk_bit("fab_in_q", 1'h1, fab_in_q);
    c.in_reg = 1'h1;
    c.in_dly = 1'h1;
    setcfg(c);
    cedge();
    ext_val <= 1'h0;
    tick(6);
    chk_bit("fab_in_q", 1'h1, fab_in_q);
    cedge();
    chk_bit("fab_in_q", 1'h0, fab_in_q);
    ext_val <= 1'h1;
    tick(4);
    scan_capture <= 1'h1;
    tck_pulse();
    scan_capture <= 1'h0;
    scan_shift <= 1'h1;
    tck_pulse();
    chk_bit("scan_tdo_q", 1'h1, scan_tdo_q);
    // shift ones into the enable and data stages, update, then let extest take the pad
    scan_tdi <= 1'h1;
    tck_pulse();
    tck_pulse();
    scan_shift <= 1'h0;
    scan_update <= 1'h1;
    tck_pulse();
    scan_update <= 1'h0;
    scan_extest <= 1'h1;
    fab_o <= 1'h0;
    tick(4);
    chk_bit("pad_oe_q extest", 1'h1, pad_oe_q);
    chk_bit("pad_o_q extest", 1'h1, pad_o_q);
    conclude();
  end
endmodule
